// ### rtl/sac_map.svh
// Register map, field positions and timing counts for the SAR converter
// control block. Definitions only; included by the design files.
`ifndef SAC_MAP_SVH
`define SAC_MAP_SVH

// ==========================================================
// Register byte offsets (one 32-bit word each)
`define SAC_OFF_CTL0    8'h00
`define SAC_OFF_CTL1    8'h04
`define SAC_OFF_RESH    8'h08
`define SAC_OFF_RESL    8'h0c
`define SAC_OFF_STAT    8'h10

// ==========================================================
// Field positions
`define SAC_C0_ON       0
`define SAC_C0_GO       1
`define SAC_C0_CHS_LO   2
`define SAC_C0_CHS_HI   5
`define SAC_C0_REF      6
`define SAC_C0_JUST     7
`define SAC_C1_CLK_LO   4
`define SAC_C1_CLK_HI   6
`define SAC_ST_DONE     0

// ==========================================================
// Sequencing counts in bit periods, plus the MSB trial code and the RC clock code
`define SAC_RES_BITS    4'd10
`define SAC_GAP_LAST    2'd1
`define SAC_MSB_TRIAL   10'h200
`define SAC_RC_CODE     2'h3

`endif

// ### rtl/sac_pkg.sv
// Types for the SAR converter control block.
// Assumes the map header supplies all numbers.
package sac_pkg;

	// ==========================================================
	// Sequencer states, one-hot
	typedef enum logic [2:0]
	{
		SAC_IDLE = 3'b001,
		SAC_CONV = 3'b010,
		SAC_GAP  = 3'b100
	} sac_state_t;

	// ==========================================================
	// Whole block state
	typedef struct packed
	{
		sac_state_t  st;
		logic        ack;
		logic [31:0] dat;
		logic        justify;
		logic        ref_ext;
		logic [3:0]  channel_select;
		logic        go;
		logic        on;
		logic [2:0]  clk_sel;
		logic        done;
		logic [9:0]  result;
		logic [9:0]  trial;
		logic [3:0]  bitn;
		logic [5:0]  div;
		logic [1:0]  gap;
		logic        comp_m;
		logic        comp_s;
		logic        rc_m;
		logic        rc_s;
		logic        rc_p;
	} sac_reg_t;

endpackage : sac_pkg

// ### rtl/sac_top.sv
// SAR converter control: register file on classic Wishbone, conversion
// clock selection, 11 bit-period successive approximation sequencer.
// Assumes an analog front end outside: mux, sample-and-hold, DAC and
// comparator; comp_i and rc_clk_i arrive asynchronous to clk_i.
//
// Functional notes
// - Ten-bit SAR result into result registers
// - One channel routed to shared sample-hold
// - channel_select picks the connected input
// - ref_source_select picks supply or external
// - Negative reference always ground
// - Three-bit clock select, seven sources
// - One conversion clock period per bit
// - Conversion spans eleven bit periods
// - Divided sources track system clock
// - RC source gives about 4us period
// - Completion raises interrupt flag
// - Completion flag can wake device
// - Go starts when on, stays high
// - Finish clears go, sets done, stores
// - Abort keeps result, two-period gap
// - result_justify picks right or left
`timescale 1ns/1ps
`include "sac_map.svh"

module sac_top
(
	input  wire logic        clk_i,     // 10 MHz system clock
	input  wire logic        resetn_i,  // Sync reset, active low
	input  wire logic        wb_cyc_i,  // Bus cycle
	input  wire logic        wb_stb_i,  // Strobe
	input  wire logic        wb_we_i,   // Write enable
	input  wire logic [7:0]  wb_adr_i,  // Byte address
	input  wire logic [3:0]  wb_sel_i,  // Byte lanes
	input  wire logic [31:0] wb_dat_i,  // Write data
	output logic      [31:0] wb_dat_o,  // Read data
	output logic             wb_ack_o,  // Acknowledge
	input  wire logic        comp_i,    // Comparator: input >= trial
	input  wire logic        rc_clk_i,  // Dedicated RC oscillator
	output logic      [3:0]  chan_o,    // Mux channel select
	output logic             ref_ext_o, // 1: external positive ref
	output logic             power_o,   // Converter powered
	output logic             hold_o,    // Sample-hold in hold
	output logic      [9:0]  trial_o,   // DAC trial code
	output logic             done_o     // Completion flag, wakes
);
	import sac_pkg::*;

	// ==========================================================
	// State and next state
	sac_reg_t s_q;
	sac_reg_t s_d;

	localparam sac_reg_t SAC_RST = '{st: SAC_IDLE, default: '0};

	logic       rc_mode;
	logic [2:0] expo;
	logic [5:0] lim;
	logic       tick;
	logic       req;
	logic       wr;
	logic       wr_c0;
	logic       wr_c1;
	logic       clr_done;
	logic [9:0] mask;
	logic [9:0] cur;
	logic [7:0] adr;

	// Word-aligned address; the two low bits do not select
	assign adr = {wb_adr_i[7:2], 2'b00};

	// ==========================================================
	// Bit-period tick; divided sources follow clk_i, so a change
	// of system clock rate moves the bit period with it
	assign rc_mode = (s_q.clk_sel[1:0] == `SAC_RC_CODE);
	assign expo    = {s_q.clk_sel[1:0], 1'b0}
	               + {2'b00, s_q.clk_sel[2]} + 3'd1;
	assign lim     = 6'((7'd1 << expo) - 7'd1);
	// RC edge is taken only from the second and third stages
	assign tick    = rc_mode ? (s_q.rc_s & ~s_q.rc_p)
	                         : (s_q.div == lim);

	// ==========================================================
	// Bus decode; writes land on the edge that sees ack high
	assign req      = wb_cyc_i & wb_stb_i;
	assign wr       = req & wb_we_i & s_q.ack & wb_sel_i[0];
	assign wr_c0    = wr & (adr == `SAC_OFF_CTL0);
	assign wr_c1    = wr & (adr == `SAC_OFF_CTL1);
	assign clr_done = wr & (adr == `SAC_OFF_STAT)
	                & wb_dat_i[`SAC_ST_DONE];

	// Trial bit under test, MSB first
	// The comparator reaches comp_s two clocks after a trial change,
	// so the /2 source decides each bit on the previous trial. That
	// bit period is below the minimum anyway; software must not use
	// it for real conversions at this clock rate.
	assign mask = `SAC_MSB_TRIAL >> (s_q.bitn - 4'd1);
	assign cur  = s_q.comp_s ? s_q.trial : (s_q.trial & ~mask);

	// ==========================================================
	// Next-state logic
	always_comb
	begin
		s_d = s_q;

		// Two-stage synchronisers, plus an edge stage for RC
		s_d.comp_m = comp_i;
		s_d.comp_s = s_q.comp_m;
		s_d.rc_m   = rc_clk_i;
		s_d.rc_s   = s_q.rc_m;
		s_d.rc_p   = s_q.rc_s;

		// Divider free-runs during a conversion or gap
		if (tick || s_q.st == SAC_IDLE)
			s_d.div = '0;
		else
			s_d.div = s_q.div + 6'd1;

		// One wait state; ack drops the cycle after it rose
		s_d.ack = req & ~s_q.ack;
		if (req && !s_q.ack)
		begin
			case (adr)
				`SAC_OFF_CTL0:
					s_d.dat = {24'h0, s_q.justify, s_q.ref_ext,
					           s_q.channel_select, s_q.go, s_q.on};
				`SAC_OFF_CTL1:
					s_d.dat = {25'h0, s_q.clk_sel, 4'h0};
				// Justify 1 is right, 0 is left
				`SAC_OFF_RESH:
					s_d.dat = s_q.justify
					        ? {30'h0, s_q.result[9:8]}
					        : {24'h0, s_q.result[9:2]};
				`SAC_OFF_RESL:
					s_d.dat = s_q.justify
					        ? {24'h0, s_q.result[7:0]}
					        : {24'h0, s_q.result[1:0], 6'h0};
				`SAC_OFF_STAT:
					s_d.dat = {31'h0, s_q.done};
				default:
					s_d.dat = 32'h0;
			endcase
		end

		// Configuration fields, writable in any state
		if (wr_c0)
		begin
			s_d.justify = wb_dat_i[`SAC_C0_JUST];
			s_d.ref_ext = wb_dat_i[`SAC_C0_REF];
			s_d.channel_select     = wb_dat_i[`SAC_C0_CHS_HI:`SAC_C0_CHS_LO];
			s_d.on      = wb_dat_i[`SAC_C0_ON];
		end
		if (wr_c1)
			s_d.clk_sel = wb_dat_i[`SAC_C1_CLK_HI:`SAC_C1_CLK_LO];

		// Done is write-one-to-clear; completion wins a tie
		if (clr_done)
			s_d.done = 1'b0;

		// ======================================================
		// Sequencer
		case (s_q.st)
			SAC_IDLE:
			begin
				// Converter must already be on; go with on in the
				// same write is refused
				if (wr_c0 && wb_dat_i[`SAC_C0_GO] && s_q.on)
				begin
					s_d.go    = 1'b1;
					s_d.st    = SAC_CONV;
					s_d.bitn  = 4'd0;
					s_d.trial = 10'h0;
					s_d.div   = '0;
				end
			end
			SAC_CONV:
			begin
				// Go cleared or power off aborts; result kept
				if (!s_d.on || (wr_c0 && !wb_dat_i[`SAC_C0_GO]))
				begin
					s_d.go    = 1'b0;
					s_d.st    = SAC_GAP;
					s_d.gap   = 2'd0;
					s_d.trial = 10'h0;
				end
				else if (tick)
				begin
					if (s_q.bitn == 4'd0)
					begin
						// Setup period ends, MSB trial begins
						s_d.trial = `SAC_MSB_TRIAL;
						s_d.bitn  = 4'd1;
					end
					else if (s_q.bitn == `SAC_RES_BITS)
					begin
						// Eleventh period ends the conversion
						s_d.result = cur;
						s_d.go     = 1'b0;
						s_d.done   = 1'b1;
						s_d.trial  = 10'h0;
						s_d.st     = SAC_IDLE;
					end
					else
					begin
						s_d.trial = cur | (mask >> 1);
						s_d.bitn  = s_q.bitn + 4'd1;
					end
				end
			end
			SAC_GAP:
			begin
				// Two bit periods before acquisition resumes
				if (tick)
				begin
					s_d.gap = s_q.gap + 2'd1;
					if (s_q.gap == `SAC_GAP_LAST)
						s_d.st = SAC_IDLE;
				end
			end
			default:
				s_d.st = SAC_IDLE;
		endcase
	end

	// ==========================================================
	// State register; reset clears all fields and aborts
	always_ff @(posedge clk_i)
	begin
		if (!resetn_i)
			s_q <= SAC_RST;
		else
			s_q <= s_d;
	end

	// ==========================================================
	// Outputs straight from state flops
	// Single mux select feeds one shared sample-hold
	assign chan_o    = s_q.channel_select;
	// Only the positive reference is selectable; the negative one
	// has no control path and stays at ground
	assign ref_ext_o = s_q.ref_ext;
	assign power_o   = s_q.on;
	// One-hot code: bit 1 is the conversion state itself
	assign hold_o    = s_q.st[1];
	assign trial_o   = s_q.trial;
	// Level flag doubles as the wake request
	assign done_o    = s_q.done;
	assign wb_dat_o  = s_q.dat;
	assign wb_ack_o  = s_q.ack;

	// ==========================================================
	// Checks
	logic [3:0] tk_cnt;
	always_ff @(posedge clk_i)
	begin
		if (!resetn_i || s_q.st != SAC_CONV)
			tk_cnt <= 4'd0;
		else if (tick)
			tk_cnt <= tk_cnt + 4'd1;
	end

	sequence seq_finish;
		s_q.st == SAC_CONV && tick && s_q.bitn == `SAC_RES_BITS
		&& s_d.on && !wr_c0;
	endsequence

	sequence seq_abort;
		s_q.st == SAC_CONV && wr_c0 && !wb_dat_i[`SAC_C0_GO];
	endsequence

	chk_finish_flags: assert property (@(posedge clk_i)
		disable iff (!resetn_i)
		seq_finish |=> !go_bit() && done_o && hold_o == 1'b0)
		else $error("finish did not clear go and set done");

	chk_eleven_periods: assert property (@(posedge clk_i)
		disable iff (!resetn_i)
		seq_finish |-> tk_cnt == 4'd10)
		else $error("conversion did not span eleven periods");

	chk_abort_keeps: assert property (@(posedge clk_i)
		disable iff (!resetn_i)
		seq_abort |=> $stable(s_q.result) && s_q.st == SAC_GAP)
		else $error("abort changed result or skipped gap");

	chk_gap_two: assert property (@(posedge clk_i)
		disable iff (!resetn_i)
		s_q.st == SAC_GAP && tick && s_q.gap == 2'd0 |=>
		s_q.st == SAC_GAP)
		else $error("gap ended before two periods");

	chk_chan_follow: assert property (@(posedge clk_i)
		disable iff (!resetn_i)
		wr_c0 |=> chan_o == $past(wb_dat_i[5:2]))
		else $error("channel output did not follow write");

	chk_ref_follow: assert property (@(posedge clk_i)
		disable iff (!resetn_i)
		wr_c0 |=> ref_ext_o == $past(wb_dat_i[6]))
		else $error("reference select did not follow write");

	chk_clk_follow: assert property (@(posedge clk_i)
		disable iff (!resetn_i)
		wr_c1 |=> s_q.clk_sel == $past(wb_dat_i[6:4]))
		else $error("clock select did not follow write");

	chk_div_spacing: assert property (@(posedge clk_i)
		disable iff (!resetn_i)
		tick && !rc_mode && s_q.st != SAC_IDLE |=> !tick)
		else $error("divided ticks closer than two clocks");

	chk_msb_first: assert property (@(posedge clk_i)
		disable iff (!resetn_i)
		s_q.st == SAC_CONV && tick && s_q.bitn == 4'd0 && s_d.on
		&& !wr_c0 |=> trial_o == 10'h200)
		else $error("first trial is not the MSB");

	chk_reset_clear: assert property (@(posedge clk_i)
		!resetn_i |=> s_q.clk_sel == 3'h0 && chan_o == 4'h0
		&& !ref_ext_o && !s_q.justify && !hold_o)
		else $error("reset left a field or conversion");

	chk_ack_single: assert property (@(posedge clk_i)
		disable iff (!resetn_i)
		wb_ack_o |=> !wb_ack_o)
		else $error("ack held for two cycles");

	chk_go_held: assert property (@(posedge clk_i)
		disable iff (!resetn_i)
		hold_o |-> go_bit())
		else $error("go low during conversion");

	function automatic logic go_bit();
		return s_q.go;
	endfunction : go_bit

endmodule : sac_top

// ### tb/sac_afe_model.sv
// Analog front end model: per-channel input codes and the RC oscillator.
// Assumes the control block drives hold, channel, reference and trial.
`timescale 1ns/1ps

module sac_afe_model
(
	input  wire logic       hold_i,   // Converter in hold
	input  wire logic [3:0] chan_i,   // Selected channel
	input  wire logic       ref_i,    // External reference chosen
	input  wire logic [9:0] trial_i,  // DAC trial code
	output logic            comp_o,   // Input at or above trial
	output logic            rc_clk_o  // Free running RC clock
);
	// ==========================================================
	// Comparator; outside hold it is meaningless, so it toggles
	logic [9:0] code;
	// Channel 15 carries a full-scale input; any other channel a
	// pattern made of its own number and the reference choice
	assign code = (chan_i == 4'hf) ? 10'h3ff
	            : {chan_i, ref_i, 5'h15};
	assign comp_o = hold_i ? (code >= trial_i) : rc_clk_o;
	// Oscillator free runs, 4 us period
	initial rc_clk_o = 1'b0;
	always #2000 rc_clk_o = ~rc_clk_o;
endmodule : sac_afe_model

// ### tb/sac_top_test.sv
// Testbench for the converter control block and its front end model.
// Assumes a 10 MHz clock and Wishbone responses within the timeout.
`timescale 1ns/1ps

module sac_top_test;
	logic        clk_i = 0, resetn_i = 0, cyc = 0, stb = 0, we = 0;
	logic [7:0]  adr = 0;
	logic [3:0]  sel = 0;
	logic [31:0] wdat = 0, rdat, wb_dat_o;
	logic [9:0]  trial_o;
	logic [3:0]  chan_o;
	logic        wb_ack_o, comp, rc, ref_ext_o, power_o, hold_o, done_o;
	int          err_count = 0, samples_checked = 0, cycles = 0;

	sac_top i_dut (.clk_i(clk_i), .resetn_i(resetn_i), .wb_cyc_i(cyc),
		.wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
		.wb_dat_i(wdat), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
		.comp_i(comp), .rc_clk_i(rc), .chan_o(chan_o),
		.ref_ext_o(ref_ext_o), .power_o(power_o), .hold_o(hold_o),
		.trial_o(trial_o), .done_o(done_o));
	sac_afe_model i_afe (.hold_i(hold_o), .chan_i(chan_o),
		.ref_i(ref_ext_o), .trial_i(trial_o), .comp_o(comp),
		.rc_clk_o(rc));

	// ==========================================================
	// Clock and hang guard
	always #50 clk_i = ~clk_i;
	always @(posedge clk_i)
	begin
		cycles++;
		if (cycles == 20000)
		begin
			err_count++;
			end_of_test();
		end
	end

	// ==========================================================
	// Shared helpers
	task automatic chk(input logic ok, input string msg);
		samples_checked++;
		if (!ok)
		begin
			err_count++;
			$display("[FAIL] %0t %s", $time, msg);
		end
	endtask : chk

	// Classic cycle; request held until ack is sampled high
	task automatic wb(input logic w, input logic [7:0] a,
		input logic [31:0] d);
		@(posedge clk_i);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		wdat <= d;
		sel <= 4'h1;
		@(posedge clk_i);
		while (wb_ack_o !== 1'b1)
			@(posedge clk_i);
		rdat = wb_dat_o;
		cyc <= 1'b0;
		stb <= 1'b0;
	endtask : wb

	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		wb(1'b0, a, 32'h0);
		chk(rdat === e, "read data");
	endtask : rd

	// One conversion, timed and read back in the chosen format
	task automatic conv(input logic [2:0] cs, input logic [3:0] ch,
		input logic j, input logic r);
		int n;
		int dv;
		logic [9:0] v;
		dv = 2 << (cs[2] + 2 * cs[1:0]);
		v = (ch == 4'hf) ? 10'h3ff : {ch, r, 5'h15};
		wb(1'b1, 8'h04, {cs, 4'h0});
		rd(8'h04, {cs, 4'h0});
		wb(1'b1, 8'h00, {j, r, ch, 2'b01});
		repeat (20) @(posedge clk_i); // Settling after channel change
		wb(1'b1, 8'h00, {j, r, ch, 2'b11});
		#1;
		n = 0;
		while (hold_o === 1'b1)
		begin
			@(posedge clk_i);
			#1;
			n++;
		end
		if (cs[1:0] != 2'b11)
			chk(n == 11 * dv, "divided length");
		else
			chk(n > 400 && n <= 444, "rc length");
		chk(done_o === 1'b1, "done");
		chk(chan_o === ch && ref_ext_o === r, "route");
		rd(8'h00, {j, r, ch, 2'b01});
		rd(8'h08, j ? {6'h0, v[9:8]} : v[9:2]);
		rd(8'h0c, j ? v[7:0] : {v[1:0], 6'h0});
		wb(1'b1, 8'h10, 32'h1);
		@(posedge clk_i);
		#1;
		chk(done_o === 1'b0, "done clear");
	endtask : conv

	// ==========================================================
	// Scenarios
	task automatic t_reset;
		for (int a = 0; a <= 8'h14; a += 4)
			rd(a[7:0], 32'h0);
		wb(1'b1, 8'h00, 32'h3);
		repeat (3) @(posedge clk_i);
		chk(hold_o === 1'b0 && power_o === 1'b1, "go with on");
		$display("reset test done");
	endtask : t_reset

	task automatic t_codes;
		// The /2 period is below the minimum, so that code converts
		// only a full-scale input, where every decision agrees
		// RC codes stand in for conversions of a sleeping core
		for (int i = 0; i < 8; i++)
			conv(i[2:0], (i == 0) ? 4'hf : i[3:0] + 4'h3,
			     i[0], i[1]);
		$display("clock select test done");
	endtask : t_codes

	// Abort leaves the old result; go in the gap is ignored
	task automatic t_abort;
		conv(3'b101, 4'h5, 1'b1, 1'b0); // /16 keeps the period legal
		wb(1'b1, 8'h04, 32'h60);
		wb(1'b1, 8'h00, 32'h97);
		repeat (100) @(posedge clk_i);
		wb(1'b1, 8'h00, 32'h95);
		wb(1'b1, 8'h00, 32'h97);
		repeat (150) @(posedge clk_i);
		chk(hold_o === 1'b0 && done_o === 1'b0, "abort");
		rd(8'h08, 32'h1);
		rd(8'h0c, 32'h55);
		$display("abort test done");
	endtask : t_abort

	task automatic t_rst;
		wb(1'b1, 8'h00, 32'h97);
		repeat (20) @(posedge clk_i);
		resetn_i <= 1'b0;
		repeat (2) @(posedge clk_i);
		resetn_i <= 1'b1;
		@(posedge clk_i);
		#1;
		chk(hold_o === 1'b0 && power_o === 1'b0, "reset abort");
		chk(chan_o === 4'h0 && done_o === 1'b0, "reset fields");
		rd(8'h04, 32'h0);
		$display("mid reset test done");
	endtask : t_rst

	task automatic end_of_test;
		$display("Checks %0d, mismatches %0d", samples_checked, err_count);
		if (err_count == 0 && samples_checked > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask : end_of_test

	initial
	begin
		repeat (6) @(posedge clk_i);
		resetn_i <= 1'b1;
		t_reset();
		t_codes();
		t_abort();
		t_rst();
		end_of_test();
	end
endmodule : sac_top_test
